// >>> design/rvp_pkg.sv
// Constants for the regulator and bus power control block
//
// Behaviour
// - Register bit 6 reads the present, synchronised bus power level.
// - With its interrupt enabled, every bus power edge raises an interrupt.
// - The bus power interrupt is edge-only; no pending flag is kept.
// - With USB as reset source, every bus power edge requests system reset.
// - Bit 7 set disables the USB supply regulator; clear keeps it on.
// - Bit 4 selects USB supply regulator low-power suspend mode.
// - Bit 3 shuts the core regulator in stop mode; only pin reset wakes.
// - Bit 1 selects core regulator low-power mode.
// - Bit 0 powers program memory down between clocks when not fetching.
// - Memory power gating has no effect while prefetch is enabled.
// - Slow-to-fast clock change with gating stalls fetches up to 20 clocks.
package rvp_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL_ADDR = 8'hC9;
  localparam logic [7:0] REG_CTRL_RESET = 8'h00;
  // Bits software can store; bit 6 is status only
  localparam logic [7:0] REG_CTRL_WMASK = 8'hBF;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_USB_REG_DISABLE = 7;
  localparam int BIT_BUS_POWER = 6;
  localparam int BIT_USB_LOW_POWER = 4;
  localparam int BIT_STOP_REG_OFF = 3;
  localparam int BIT_CORE_LOW_POWER = 1;
  localparam int BIT_MEM_GATING = 0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  // Settle time of memory supply, counted in system clocks as printed
  localparam int MEM_SETTLE_CLOCKS = 20;
  localparam int SYNC_STAGES = 2;

  // ****************************************************************
  // Memory power states, Gray along awake -> gated -> settle
  // ****************************************************************
  typedef enum logic [1:0] {
    MP_AWAKE = 2'b00,
    MP_GATED = 2'b01,
    MP_SETTLE = 2'b11
  } rvp_mem_state_t;

endpackage

// >>> design/rvp_level_sync.sv
// Two-stage synchroniser for the bus power pin
`timescale 1ns/1ps
module rvp_level_sync (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_q;
  logic sync_q;

  // First stage feeds only the second; nothing else may look at it
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // rvp_level_sync

// >>> design/rvp_regulator_ctrl.sv
// Regulator control register, bus power detection and memory power gating
`timescale 1ns/1ps
module rvp_regulator_ctrl #(
  parameter int STALL_CLOCKS = rvp_pkg::MEM_SETTLE_CLOCKS
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Special function register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  // Bus power pin and event controls
  input wire logic vbus_pin_in,
  input wire logic vbus_irq_enable_in,
  input wire logic usb_reset_source_in,
  output logic vbus_irq_out,
  output logic vbus_reset_req_out,
  // Regulator controls
  input wire logic stop_mode_in,
  output logic usb_regulator_disable_out,
  output logic usb_regulator_low_power_out,
  output logic core_regulator_low_power_out,
  output logic core_regulator_shutdown_out,
  // Program memory power
  input wire logic prefetch_enable_in,
  input wire logic fetch_active_in,
  input wire logic clk_fast_in,
  output logic mem_power_down_out,
  output logic fetch_stall_out
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (STALL_CLOCKS < 1 || STALL_CLOCKS > 255)
  begin : g_bad_stall
    $error("STALL_CLOCKS must lie in 1..255");
  end

  localparam logic [7:0] STALL_LAST = 8'(STALL_CLOCKS - 1);

  // Address match shared by read and write paths
  function automatic logic ctrl_hit(input logic [7:0] addr);
    return addr == rvp_pkg::REG_CTRL_ADDR;
  endfunction

  logic [7:0] ctrl_q;
  logic [7:0] rdata_q;
  logic vbus_level;
  logic vbus_prev_q;
  logic vbus_edge;
  logic irq_q;
  logic rst_req_q;
  logic fast_prev_q;
  logic fast_rise;
  logic gating_active;
  logic [7:0] stall_cnt_q;
  rvp_pkg::rvp_mem_state_t mem_state_q;
  rvp_pkg::rvp_mem_state_t mem_state_d;

  // ****************************************************************
  // Bus power detection
  // ****************************************************************
  // Pin is asynchronous to the core clock
  rvp_level_sync u_vbus_sync (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(vbus_pin_in),
    .sync_out(vbus_level)
  );

  // Delayed copy for edge detection, taken after synchronisation
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      vbus_prev_q <= 1'b0;
    else
      vbus_prev_q <= vbus_level;
  end

  assign vbus_edge = vbus_level ^ vbus_prev_q;

  // Event pulses; nothing latched so software has nothing to clear
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      irq_q <= 1'b0;
      rst_req_q <= 1'b0;
    end
    else
    begin
      irq_q <= vbus_edge && vbus_irq_enable_in;
      rst_req_q <= vbus_edge && usb_reset_source_in;
    end
  end

  assign vbus_irq_out = irq_q;
  assign vbus_reset_req_out = rst_req_q;

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Reserved bits are stored as written; status bit is never stored
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      ctrl_q <= rvp_pkg::REG_CTRL_RESET;
    else if (sfr_wr_in && ctrl_hit(sfr_addr_in))
      ctrl_q <= sfr_wdata_in & rvp_pkg::REG_CTRL_WMASK;
  end

  // Registered read; other addresses answer zero on the shared bus
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      rdata_q <= 8'h00;
    else if (sfr_rd_in && ctrl_hit(sfr_addr_in))
    begin
      rdata_q <= ctrl_q;
      rdata_q[rvp_pkg::BIT_BUS_POWER] <= vbus_level;
    end
    else
      rdata_q <= 8'h00;
  end

  assign sfr_rdata_out = rdata_q;

  // Regulator control levels
  assign usb_regulator_disable_out = ctrl_q[rvp_pkg::BIT_USB_REG_DISABLE];
  assign usb_regulator_low_power_out = ctrl_q[rvp_pkg::BIT_USB_LOW_POWER];
  assign core_regulator_low_power_out = ctrl_q[rvp_pkg::BIT_CORE_LOW_POWER];
  // Shutdown removes all wake paths but the reset pin, so only in stop
  assign core_regulator_shutdown_out =
    stop_mode_in && ctrl_q[rvp_pkg::BIT_STOP_REG_OFF];

  // ****************************************************************
  // Program memory power gating
  // ****************************************************************
  // Prefetch keeps memory busy continuously, so gating is overridden
  assign gating_active = ctrl_q[rvp_pkg::BIT_MEM_GATING] && !prefetch_enable_in;

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      fast_prev_q <= 1'b0;
    else
      fast_prev_q <= clk_fast_in;
  end

  assign fast_rise = clk_fast_in && !fast_prev_q;

  // Next state of the memory power sequencer
  always_comb
  begin
    mem_state_d = mem_state_q;
    case (mem_state_q)
      rvp_pkg::MP_AWAKE:
        if (gating_active && fast_rise)
          mem_state_d = rvp_pkg::MP_SETTLE;
        else if (gating_active)
          mem_state_d = rvp_pkg::MP_GATED;
      rvp_pkg::MP_GATED:
        if (!gating_active)
          mem_state_d = rvp_pkg::MP_AWAKE;
        else if (fast_rise)
          mem_state_d = rvp_pkg::MP_SETTLE;
      rvp_pkg::MP_SETTLE:
        if (stall_cnt_q == STALL_LAST)
          mem_state_d = gating_active ? rvp_pkg::MP_GATED : rvp_pkg::MP_AWAKE;
      default:
        mem_state_d = rvp_pkg::MP_AWAKE;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      mem_state_q <= rvp_pkg::MP_AWAKE;
    else
      mem_state_q <= mem_state_d;
  end

  // Settle counter runs only while stalling
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      stall_cnt_q <= 8'h00;
    else if (mem_state_q == rvp_pkg::MP_SETTLE && stall_cnt_q != STALL_LAST)
      stall_cnt_q <= stall_cnt_q + 8'h01;
    else
      stall_cnt_q <= 8'h00;
  end

  // Memory is off only between fetches; settle keeps the supply up
  // Gating is checked again here so prefetch wins at once, not a state later
  assign mem_power_down_out =
    (mem_state_q == rvp_pkg::MP_GATED) && gating_active && !fetch_active_in;
  assign fetch_stall_out = (mem_state_q == rvp_pkg::MP_SETTLE);

  // ****************************************************************
  // Assertion helpers
  // ****************************************************************
  // Run length of the stall, counted apart from the sequencer's own counter
  logic [8:0] stall_seen_q;

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      stall_seen_q <= 9'h000;
    else if (fetch_stall_out)
      stall_seen_q <= stall_seen_q + 9'h001;
    else
      stall_seen_q <= 9'h000;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_ctrl_write;
    sfr_wr_in && ctrl_hit(sfr_addr_in);
  endsequence

  sequence s_settle_start;
    gating_active && fast_rise && mem_state_q != rvp_pkg::MP_SETTLE;
  endsequence

  a_status_read_level: assert property (
    sfr_rd_in && ctrl_hit(sfr_addr_in)
      |=> sfr_rdata_out[rvp_pkg::BIT_BUS_POWER] == $past(vbus_level))
    else $error("status bit differs from bus power level");

  a_irq_on_edge: assert property (
    vbus_edge && vbus_irq_enable_in |=> vbus_irq_out)
    else $error("bus power edge gave no interrupt");

  a_irq_only_edge: assert property (
    !vbus_edge |=> !vbus_irq_out)
    else $error("interrupt without a bus power edge");

  a_reset_on_edge: assert property (
    $changed(vbus_level) && usb_reset_source_in |=> vbus_reset_req_out)
    else $error("bus power edge gave no reset request");

  a_reset_only_edge: assert property (
    !vbus_edge |=> !vbus_reset_req_out)
    else $error("reset request without a bus power edge");

  a_usb_disable_write: assert property (
    s_ctrl_write |=> usb_regulator_disable_out == $past(sfr_wdata_in[7]))
    else $error("USB regulator disable not taken from write");

  a_usb_low_power: assert property (
    s_ctrl_write |=> usb_regulator_low_power_out == $past(sfr_wdata_in[4]))
    else $error("USB regulator mode not taken from write");

  a_stop_shutdown: assert property (
    core_regulator_shutdown_out |-> stop_mode_in && ctrl_q[3])
    else $error("core regulator shut down outside stop mode");

  a_core_low_power: assert property (
    s_ctrl_write |=> core_regulator_low_power_out == $past(sfr_wdata_in[1]))
    else $error("core regulator mode not taken from write");

  a_core_mode_holds: assert property (
    !(sfr_wr_in && ctrl_hit(sfr_addr_in)) |=> $stable(core_regulator_low_power_out))
    else $error("core regulator mode changed without a write");

  a_usb_modes_hold: assert property (
    !(sfr_wr_in && ctrl_hit(sfr_addr_in))
      |=> $stable(usb_regulator_disable_out) && $stable(usb_regulator_low_power_out))
    else $error("USB regulator controls changed without a write");

  a_status_not_stored: assert property (
    s_ctrl_write |=> !ctrl_q[rvp_pkg::BIT_BUS_POWER])
    else $error("status bit stored from a write");

  a_gate_no_fetch: assert property (
    mem_power_down_out |-> !fetch_active_in && ctrl_q[0])
    else $error("memory powered down during fetch or with gating off");

  a_prefetch_blocks: assert property (
    prefetch_enable_in |-> !mem_power_down_out)
    else $error("memory gated while prefetch enabled");

  // Stall length is checked by the helper counter, so any parameter value works
  sequence s_stall_end;
    fetch_stall_out ##1 !fetch_stall_out;
  endsequence

  a_settle_stall: assert property (
    s_settle_start |=> fetch_stall_out)
    else $error("clock speed-up gave no settle stall");

  a_stall_length: assert property (
    s_stall_end |-> stall_seen_q == 9'(STALL_CLOCKS))
    else $error("settle stall ended at the wrong length");

  a_stall_bounded: assert property (
    fetch_stall_out |-> stall_seen_q < 9'(STALL_CLOCKS))
    else $error("settle stall ran past its limit");

  a_gating_enters: assert property (
    gating_active && !fast_rise && mem_state_q == rvp_pkg::MP_AWAKE
      |=> mem_state_q == rvp_pkg::MP_GATED)
    else $error("gating enabled but memory not gated");

endmodule // rvp_regulator_ctrl

// >>> tb/rvp_vbus_host.sv
// Bus power line model, pin changes unrelated to the system clock
`timescale 1ns/1ps
module rvp_vbus_host (
  input wire logic level_in,
  input wire logic slow_in,
  output logic vbus_out
);
  // ****************************************************************
  // Line driver
  // ****************************************************************
  initial vbus_out = 1'b0;
  // Off-edge delays so the pin lands mid-cycle, the synchroniser's hard case
  always @(level_in)
  begin
    if (slow_in)
      vbus_out <= #13.3 level_in;
    else
      vbus_out <= #1.7 level_in;
  end
endmodule // rvp_vbus_host

// >>> tb/regulator_vbus_power_control_tb.sv
// Self-checking bench for the regulator and bus power control block
`timescale 1ns/1ps
module regulator_vbus_power_control_tb;
  localparam int STALL = 4;
  logic mclk_in, sys_rst_in, sfr_wr_in, sfr_rd_in, vbus_pin_in, vbus_req, vbus_slow;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, ctrl_m, w, d;
  logic vbus_irq_enable_in, usb_reset_source_in, vbus_irq_out, vbus_reset_req_out;
  logic stop_mode_in, usb_regulator_disable_out, usb_regulator_low_power_out;
  logic core_regulator_low_power_out, core_regulator_shutdown_out, prefetch_enable_in;
  logic fetch_active_in, clk_fast_in, mem_power_down_out, fetch_stall_out, vbus_m;
  int n_mismatch, n_compared, ni, nr;

  // ****************************************************************
  // Design, line model and clock
  // ****************************************************************
  rvp_regulator_ctrl #(.STALL_CLOCKS(STALL)) u_rvp_regulator_ctrl (.mclk_in, .sys_rst_in,
    .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in, .sfr_rdata_out, .vbus_pin_in,
    .vbus_irq_enable_in, .usb_reset_source_in, .vbus_irq_out, .vbus_reset_req_out,
    .stop_mode_in, .usb_regulator_disable_out, .usb_regulator_low_power_out,
    .core_regulator_low_power_out, .core_regulator_shutdown_out, .prefetch_enable_in,
    .fetch_active_in, .clk_fast_in, .mem_power_down_out, .fetch_stall_out);
  rvp_vbus_host u_rvp_vbus_host (.level_in(vbus_req), .slow_in(vbus_slow),
    .vbus_out(vbus_pin_in));
  // 200 MHz system clock
  initial
  begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  // Hang guard, well past the longest sequence
  initial
  begin
    #100000;
    n_mismatch++;
    test_done();
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic test_done();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= v;
    sfr_wr_in <= 1'b1;
    @(posedge mclk_in);
    sfr_wr_in <= 1'b0;
  endtask
  // Read data is registered, so it is taken just after the sampling edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(posedge mclk_in);
    sfr_rd_in <= 1'b0;
    #1 v = sfr_rdata_out;
  endtask
  task automatic check_regs();
    rd_reg(rvp_pkg::REG_CTRL_ADDR, d);
    chk("ctrl", d, (ctrl_m & rvp_pkg::REG_CTRL_WMASK) | {1'b0, vbus_m, 6'h0});
    chk("levels", {4'h0, usb_regulator_disable_out, usb_regulator_low_power_out,
      core_regulator_low_power_out, core_regulator_shutdown_out}, {4'h0, ctrl_m[7],
      ctrl_m[4], ctrl_m[1], stop_mode_in & ctrl_m[3]});
  endtask
  // Pulses are counted over a fixed span longer than the sync latency
  task automatic edge_cnt();
    ni = 0;
    nr = 0;
    repeat (8)
    begin
      @(posedge mclk_in);
      #1;
      ni += int'(vbus_irq_out === 1'b1);
      nr += int'(vbus_reset_req_out === 1'b1);
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {sys_rst_in, sfr_wr_in, sfr_rd_in, vbus_req, vbus_slow, vbus_irq_enable_in} = 6'h20;
    {usb_reset_source_in, stop_mode_in, prefetch_enable_in, fetch_active_in} = 4'h1;
    {sfr_addr_in, sfr_wdata_in, clk_fast_in, ctrl_m, vbus_m} = 0;
    n_mismatch = 0;
    n_compared = 0;
    void'($urandom(87372));
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    check_regs();
    // Random control values, firmware keeps reserved bits and core mode legal
    for (int i = 0; i < 8; i++)
    begin
      w = (i == 0) ? 8'hC8 : ((i == 1) ? 8'h5B : 8'($urandom));
      w[5] = 1'b0;
      w[2] = 1'b0;
      if (w[7])
        w[1] = 1'b0;
      // First two passes force stop on and off with the shutdown bit set
      @(posedge mclk_in);
      stop_mode_in <= (i < 2) ? (i == 0) : 1'($urandom);
      wr_reg(rvp_pkg::REG_CTRL_ADDR, w);
      ctrl_m = w;
      // Core low power needs 12 instruction clocks before the oscillator may stop
      if (w[1])
        repeat (12) @(posedge mclk_in);
      check_regs();
    end
    // Unmapped address neither stores nor answers
    wr_reg(8'hC8, 8'hFF);
    rd_reg(8'hC8, d);
    chk("unmapped", d, 8'h00);
    check_regs();
    // Every enable pair with prompt and slow pin; edges rise with interrupt disabled, fall with it enabled
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk_in);
      vbus_irq_enable_in <= i[0];
      usb_reset_source_in <= i[1];
      vbus_slow <= i[2];
      vbus_req <= ~vbus_req;
      vbus_m = ~vbus_m;
      edge_cnt();
      chk("irq pulses", 8'(ni), {7'h0, i[0]});
      chk("reset pulses", 8'(nr), {7'h0, i[1]});
      check_regs();
    end
    // Gating on a slow clock, then a slow-to-fast change and prefetch override
    wr_reg(rvp_pkg::REG_CTRL_ADDR, 8'h01);
    ctrl_m = 8'h01;
    repeat (2) @(posedge mclk_in);
    fetch_active_in <= 1'b0;
    @(posedge mclk_in);
    #1 chk("idle gated", {7'h0, mem_power_down_out}, 8'h01);
    @(posedge mclk_in);
    fetch_active_in <= 1'b1;
    #1 chk("fetch awake", {7'h0, mem_power_down_out}, 8'h00);
    @(posedge mclk_in);
    clk_fast_in <= 1'b1;
    ni = 0;
    repeat (STALL + 6)
    begin
      @(posedge mclk_in);
      #1 ni += int'(fetch_stall_out === 1'b1);
    end
    chk("stall length", 8'(ni), 8'(STALL));
    @(posedge mclk_in);
    prefetch_enable_in <= 1'b1;
    fetch_active_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1 chk("prefetch override", {7'h0, mem_power_down_out}, 8'h00);
    check_regs();
    test_done();
  end
endmodule // regulator_vbus_power_control_tb
